// File: hdl/gfe_input_filter.sv
// Glitch filter, edge interrupt detection and APB register file for isolated inputs.
`timescale 1ns/1ps

// Functional notes
// R1: Every input channel feeds the edge interrupt logic, so any channel can request an interrupt.
// R2: Separate per-channel rising and falling enable registers select which transitions interrupt.
// R3: All interrupt sources merge onto one interrupt output; its host level is set outside.
// R4: Software uses an interrupt state, a rising enable, a falling enable and a port id register.
// R5: Pulses of at least one interval always pass and pulses of half an interval or less never do.
// R6: Filtering is enabled or bypassed per channel by software.
// R7: One shared interval, programmable from 200 ns to 400 s, applies to all filtered channels.
// R8: Every input is sampled on each 100 ns sample tick.
// R9: A counter makes the filter tick with a period of half the programmed interval.
// R10: A filtered output changes only after the sample held its level at two filter ticks in a row.
// R11: The preset register, all 32 bits of it, times the filter tick.
// R12: A stable transition reaches the output within two filter ticks, one full interval.
// R13: Falling transitions are filtered exactly like rising ones.
// R14: An enabled edge of a filtered input sets a pending flag; the interrupt stays high meanwhile. Code: irq follows only flags whose irq_mask bit is set.
// R15: Writing ones to the interrupt state clears flags; the interrupt drops when none remain.
module gfe_input_filter
    import gfe_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Field inputs, already past the opto isolators.
    input wire logic [NUM_CH-1:0] isolated_input_port_bits,
    // Interrupt request.
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    gfe_cfg_type cfg_q;
    logic [NUM_CH-1:0] irq_state_q;
    logic [NUM_CH-1:0] filt_out_q;
    logic [NUM_CH-1:0] edge_event;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [NUM_PORTS-1:0] port_pending;
    logic wr_acc;
    logic [31:0] wmask;
    logic [NUM_CH-1:0] irq_live;

    // Byte lanes of the data bus; each strobe bit guards one lane.
    localparam int NUM_LANES = 4;
    localparam int LANE_W = 8;

    assign wr_acc = psel && penable && pwrite;

    always_comb begin
        for (int b = 0; b < NUM_LANES; b++) begin
            wmask[b*LANE_W +: LANE_W] = {LANE_W{pstrb[b]}};
        end
    end

    // Pending flags that are not masked; the port summary and the request both use them.
    assign irq_live = irq_state_q & cfg_q.irq_mask;

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            port_pending[p] = |irq_live[p*PORT_W +: PORT_W];
        end
    end

    // Unstrobed lanes keep their bits, so software may update one port of a register alone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q.filter_en <= RST_FILTER_EN;
            cfg_q.filter_preset <= RST_FILTER_PRESET;
            cfg_q.rise_en <= RST_EDGE_EN;
            cfg_q.fall_en <= RST_EDGE_EN;
            cfg_q.irq_mask <= RST_IRQ_MASK;
        end else if (wr_acc) begin
            unique case (paddr)
                ADDR_FILTER_EN: begin
                    cfg_q.filter_en <= (cfg_q.filter_en & ~wmask) | (pwdata & wmask); // [R6]
                end
                ADDR_FILTER_PRESET: begin
                    cfg_q.filter_preset <= (cfg_q.filter_preset & ~wmask) | (pwdata & wmask); // [R11]
                end
                ADDR_RISE_EN: begin
                    cfg_q.rise_en <= (cfg_q.rise_en & ~wmask) | (pwdata & wmask); // [R2]
                end
                ADDR_FALL_EN: begin
                    cfg_q.fall_en <= (cfg_q.fall_en & ~wmask) | (pwdata & wmask); // [R2]
                end
                ADDR_IRQ_MASK: begin
                    cfg_q.irq_mask <= (cfg_q.irq_mask & ~wmask) | (pwdata & wmask);
                end
                default: begin
                end
            endcase
        end
    end

    // A new event beats a clear in the same cycle, so no edge is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_state_q <= '0;
        end else begin
            if (wr_acc && paddr == ADDR_IRQ_STATE) begin
                irq_state_q <= (irq_state_q & ~(pwdata & wmask)) | edge_event; // [R15]
            end else begin
                irq_state_q <= irq_state_q | edge_event; // [R14]
            end
        end
    end

    // Unaligned or unmapped offsets answer with an error and zero data.
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        unique case (paddr)
            ADDR_INPUT_STATE: begin
                rd_word = filt_out_q;
            end
            ADDR_FILTER_EN: begin
                rd_word = cfg_q.filter_en;
            end
            ADDR_FILTER_PRESET: begin
                rd_word = cfg_q.filter_preset;
            end
            ADDR_RISE_EN: begin
                rd_word = cfg_q.rise_en;
            end
            ADDR_FALL_EN: begin
                rd_word = cfg_q.fall_en;
            end
            ADDR_IRQ_STATE: begin
                rd_word = irq_state_q; // [R4]
            end
            ADDR_IRQ_MASK: begin
                rd_word = cfg_q.irq_mask;
            end
            ADDR_PORT_ID: begin
                rd_word = {{(32-NUM_PORTS){1'b0}}, port_pending}; // [R4]
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read data is captured in the setup cycle so the access cycle answers at once.
    // A write loads zero, so stale read data never shows during a write access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slverr_q <= 1'b0;
        end else if (psel && !penable) begin
            slverr_q <= !rd_hit;
        end
    end

    // Zero wait states: every access completes in its first access cycle.
    assign prdata = prdata_q;
    assign pready = 1'b1;
    // The error flag shows only while the access phase stands.
    assign pslverr = psel && penable && slverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sample tick and filter tick.

    logic [4:0] sample_cnt_q;
    logic sample_tick;
    logic [31:0] filt_cnt_q;
    logic filt_tick;
    logic preset_hit;

    assign sample_tick = (sample_cnt_q == SAMPLE_DIV_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_cnt_q <= '0;
        end else if (sample_tick) begin
            sample_cnt_q <= '0;
        end else begin
            sample_cnt_q <= sample_cnt_q + 5'h01; // [R8]
        end
    end

    // Half interval is preset+1 sample periods: preset 0 gives a 200 ns interval and the
    // full word reaches beyond 400 s. A preset rewrite takes effect at once, with no wait for a wrap.
    // Comparing with >= rather than == lets a smaller preset act at once instead of
    // waiting for the counter to wrap through its whole range.
    assign preset_hit = (filt_cnt_q >= cfg_q.filter_preset);

    // The filter tick always falls on a sample tick, so both grids stay aligned.
    assign filt_tick = sample_tick && preset_hit; // [R9] [R11]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_cnt_q <= '0;
        end else if (filt_tick) begin
            filt_cnt_q <= '0;
        end else if (sample_tick) begin
            filt_cnt_q <= filt_cnt_q + 32'h0000_0001; // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel filter and edge detection.

    logic [NUM_CH-1:0] sample_q;
    logic [NUM_CH-1:0] cand_q;
    logic [NUM_CH-1:0] prev_out_q;
    logic [NUM_CH-1:0] filt_next;
    logic [NUM_CH-1:0] agree;

    // Sampling only on the tick means a pulse shorter than one sample period may be
    // missed even with filtering off; that is the price of a 100 ns sampling grid.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_q <= '0;
        end else if (sample_tick) begin
            sample_q <= isolated_input_port_bits; // [R8]
        end
    end

    // The candidate remembers the sample seen at the previous filter tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cand_q <= '0;
        end else if (filt_tick) begin
            cand_q <= sample_q; // [R10]
        end
    end

    // A channel agrees when its sample still equals the one seen at the previous tick.
    assign agree = ~(sample_q ^ cand_q);

    // Level-symmetric: the same test applies for 0-to-1 and 1-to-0 changes.
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (!cfg_q.filter_en[c]) begin
                filt_next[c] = sample_q[c]; // [R6]
            end else if (filt_tick && agree[c]) begin
                filt_next[c] = sample_q[c]; // [R5] [R10] [R12] [R13]
            end else begin
                filt_next[c] = filt_out_q[c];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_out_q <= '0;
        end else begin
            filt_out_q <= filt_next;
        end
    end

    // Both stages reset to zero, so a quiet low input gives no false edge after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_out_q <= '0;
        end else begin
            prev_out_q <= filt_out_q;
        end
    end

    logic [NUM_CH-1:0] rise_event;
    logic [NUM_CH-1:0] fall_event;

    assign rise_event = filt_out_q & ~prev_out_q & cfg_q.rise_en; // [R1] [R2]
    assign fall_event = ~filt_out_q & prev_out_q & cfg_q.fall_en; // [R2] [R13]
    assign edge_event = rise_event | fall_event; // [R14]

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request.

    // A level output: how the level reaches the host processor is decided outside.
    // Masking hides a flag from the request but leaves it readable and pending.
    assign irq = |irq_live; // [R3] [R14] [R15]

endmodule

// File: hdl/gfe_pkg.sv
// Package with register map, field layouts and timing constants of the input filter block.
package gfe_pkg;

    localparam int NUM_CH = 32;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;

    localparam int CLK_PERIOD_NS = 5;
    localparam int SAMPLE_PERIOD_NS = 100;
    localparam int SAMPLE_DIV = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] SAMPLE_DIV_LAST = 5'(SAMPLE_DIV - 1);

    localparam logic [11:0] ADDR_INPUT_STATE = 12'h000;
    localparam logic [11:0] ADDR_FILTER_EN = 12'h004;
    localparam logic [11:0] ADDR_FILTER_PRESET = 12'h008;
    localparam logic [11:0] ADDR_RISE_EN = 12'h00c;
    localparam logic [11:0] ADDR_FALL_EN = 12'h010;
    localparam logic [11:0] ADDR_IRQ_STATE = 12'h014;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
    localparam logic [11:0] ADDR_PORT_ID = 12'h01c;

    localparam logic [31:0] RST_FILTER_EN = 32'h0000_0000;
    localparam logic [31:0] RST_FILTER_PRESET = 32'h0000_0000;
    localparam logic [31:0] RST_EDGE_EN = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_MASK = 32'hffff_ffff;

    typedef struct packed {
        logic [NUM_CH-1:0] filter_en;
        logic [31:0] filter_preset;
        logic [NUM_CH-1:0] rise_en;
        logic [NUM_CH-1:0] fall_en;
        logic [NUM_CH-1:0] irq_mask;
    } gfe_cfg_type;

endpackage

// File: dv/gfe_field_model.sv
// Field-side model: steady input levels with timed pulses on chosen lines.
`timescale 1ns/1ps
module gfe_field_model
    import gfe_pkg::*;
(
    // Requests from the bench.
    input wire logic pclk,
    input wire logic [NUM_CH-1:0] lvl,
    input wire logic [NUM_CH-1:0] flip,
    input wire logic [15:0] len,
    input wire logic go,
    // Opto outputs towards the block.
    output logic [NUM_CH-1:0] pins
);
    int n = 0;
    // Opto outputs are always driven, so a pulse inverts the chosen lines for exactly len cycles.
    always @(posedge pclk) begin
        n <= go ? int'(len) : (n > 0 ? n - 1 : 0);
    end
    assign pins = n > 0 ? lvl ^ flip : lvl;
endmodule

// File: dv/gfe_input_filter_checker.sv
// Port-level checker of the input filter block, with its bind.
`timescale 1ns/1ps
module gfe_input_filter_checker
    import gfe_pkg::*;
(
    // Watched ports of the block.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_CH-1:0] isolated_input_port_bits,
    input wire logic irq
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr;
    int quiet_q;
    assign wr = psel && penable && pwrite;
    // At preset 3 an edge needs under 200 cycles, so 400 quiet cycles leave none in flight.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 0;
        end else if (wr || $changed(isolated_input_port_bits)) begin
            quiet_q <= 0;
        end else begin
            quiet_q <= quiet_q + 1;
        end
    end
    sequence access_s;
        psel && penable;
    endsequence
    sequence bad_rd_s;
        psel && !penable && !pwrite && (paddr > ADDR_PORT_ID || paddr[1:0] != 2'b00)
            ##1 access_s;
    endsequence
    ready_high_a: assert property (pready) else $error("ready low");
    err_access_a: assert property (pslverr |-> psel && penable) else $error("stray err");
    bad_err_a: assert property (access_s |-> pslverr == (paddr > ADDR_PORT_ID
        || paddr[1:0] != 2'b00))
        else $error("err flag");
    rd_zero_a: assert property (bad_rd_s |-> prdata == 32'h0) else $error("bad rd");
    rd_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("rd moved");
    mask_clear_a: assert property (wr && paddr == ADDR_IRQ_MASK && pwdata == 0
        && pstrb == 4'hf |=> !irq) else $error("mask");
    w1c_clear_a: assert property (wr && paddr == ADDR_IRQ_STATE && pwdata == '1
        && pstrb == 4'hf && quiet_q > 400 |=> !irq) else $error("clear");
    quiet_edge_a: assert property ($rose(irq) |-> quiet_q < 400) else $error("late irq");
endmodule
////////////////////////////////////////
bind gfe_input_filter gfe_input_filter_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .isolated_input_port_bits(isolated_input_port_bits));

// File: dv/test_input_glitch_filter_edge_irq.sv
// Self-checking bench for the input filter block and its field model.
`timescale 1ns/1ps
module test_input_glitch_filter_edge_irq
    import gfe_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, irq;
    logic [NUM_CH-1:0] pins, lvl = '0, flip = '0;
    logic [15:0] len = 16'h0;
    int err_total = 0, num_checks = 0, seed = 71519, h = 0;
    initial forever #2.5 pclk = ~pclk;
    gfe_input_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .isolated_input_port_bits(pins), .irq(irq));
    gfe_field_model field (.pclk(pclk), .lvl(lvl), .flip(flip), .len(len), .go(go), .pins(pins));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] g, input logic [33:0] x);
        num_checks++;
        if (g !== x) begin
            err_total++;
            $display("mismatch at %0t: got %h exp %h", $time, g, x);
        end
    endtask
    // Read data doubles as the expected value; pslverr is expected exactly for offsets above ADDR_PORT_ID.
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 8);
        chk({pready, pslverr, w ? d : prdata}, {1'b1, a > ADDR_PORT_ID, d});
        if (pready !== 1'b1) end_sim();
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic pass_exp(int ch, int n);
        return ch < 16 ? n >= SAMPLE_DIV : n >= 2 * h;
    endfunction
    task automatic trial(input int ch, input int n, input logic en, input logic m);
        logic f;
        f = en && pass_exp(ch, n);
        @(posedge pclk);
        {flip, len, go} <= {32'h1 << ch, 16'(n), 1'b1};
        @(posedge pclk);
        go <= 1'b0;
        repeat (n + 6 * h) @(posedge pclk);
        acc(1'b0, ADDR_IRQ_STATE, f ? 32'h1 << ch : 0);
        chk(34'(irq), 34'(f && m));
        acc(1'b0, ADDR_PORT_ID, f && m ? 32'h1 << (ch / 8) : 0);
        acc(1'b1, ADDR_IRQ_STATE, '1);
        @(posedge pclk);
        chk(34'(irq), 34'h0);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, ADDR_FILTER_EN, RST_FILTER_EN);
        acc(1'b0, ADDR_FILTER_PRESET, RST_FILTER_PRESET);
        acc(1'b0, ADDR_RISE_EN, RST_EDGE_EN);
        acc(1'b0, ADDR_IRQ_MASK, RST_IRQ_MASK);
        acc(1'b0, 12'h040, 32'h0);
        acc(1'b1, ADDR_FILTER_EN, 32'hffff_0000);
        acc(1'b1, ADDR_RISE_EN, '1);
        acc(1'b1, ADDR_FALL_EN, '1);
        for (int p = 0; p < 4; p++) begin
            h = (p + 1) * SAMPLE_DIV;
            acc(1'b1, ADDR_FILTER_PRESET, 32'(p));
            acc(1'b0, ADDR_FILTER_PRESET, 32'(p));
            lvl <= {NUM_CH{p[0]}};
            repeat (6 * h) @(posedge pclk);
            acc(1'b0, ADDR_INPUT_STATE, {NUM_CH{p[0]}});
            acc(1'b1, ADDR_IRQ_STATE, '1);
            trial(16 + ($random(seed) & 15), h, 1'b1, 1'b1);
            trial(16 + ($random(seed) & 15), 2 * h, 1'b1, 1'b1);
            trial($random(seed) & 15, SAMPLE_DIV, 1'b1, 1'b1);
            $display("preset %0d done", p);
        end
        acc(1'b1, ADDR_RISE_EN, 0);
        acc(1'b1, ADDR_FALL_EN, 0);
        trial(16 + ($random(seed) & 15), 2 * h, 1'b0, 1'b1);
        acc(1'b1, ADDR_RISE_EN, '1);
        acc(1'b1, ADDR_IRQ_MASK, 0);
        trial(16 + ($random(seed) & 15), 2 * h, 1'b1, 1'b0);
        pstrb <= 4'h2;
        acc(1'b1, ADDR_RISE_EN, 32'h0);
        pstrb <= 4'hf;
        acc(1'b0, ADDR_RISE_EN, 32'hffff_00ff);
        $display("enables and mask done");
        end_sim();
    end
endmodule
